// *** src/dps_sem_host.sv ***
`timescale 1ns/100ps
`include "dps_sem_defs.svh"

module dps_sem_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Command port
  input wire logic i_cmd_valid,
  input wire dps_sem_pkg::dps_op_t i_cmd_op,
  input wire logic [`DPS_IDX_W-1:0] i_cmd_flag,
  output logic o_cmd_ready,
  // Result
  output logic o_done,
  output logic o_granted,
  output logic [`DPS_FLAG_COUNT-1:0] o_held,
  // Device pins
  output logic o_token_space_select_n,
  output logic [`DPS_IDX_W-1:0] o_flag_index_lines,
  output logic o_rw_n,
  output logic o_oe_n,
  output logic [`DPS_DATA_W-1:0] o_port_data_lines,
  output logic o_port_data_lines_oe_n,
  input wire logic [`DPS_DATA_W-1:0] i_port_data_lines
);
  import dps_sem_pkg::*;

  dps_state_t state_q, state_d;
  dps_op_t op_q, op_d;
  logic [`DPS_IDX_W-1:0] idx_q, idx_d;
  logic pend_q, pend_d;
  logic [`DPS_CNT_W-1:0] retry_q, retry_d;
  logic [`DPS_FLAG_COUNT-1:0] held_q, held_d;
  logic done_q, done_d;
  logic granted_q, granted_d;
  logic cyc_start;
  logic cyc_write;
  logic cyc_wval;
  logic cyc_done;
  logic cyc_rval;

  // ****************************************
  // Pin access sequencer
  // ****************************************

  dps_sem_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_wval(cyc_wval),
    .i_flag(idx_q),
    .o_done(cyc_done),
    .o_rval(cyc_rval),
    .o_token_space_select_n(o_token_space_select_n),
    .o_flag_index_lines(o_flag_index_lines),
    .o_rw_n(o_rw_n),
    .o_oe_n(o_oe_n),
    .o_port_data_lines(o_port_data_lines),
    .o_port_data_lines_oe_n(o_port_data_lines_oe_n),
    .i_port_data_lines(i_port_data_lines)
  );

  // ****************************************
  // Command sequencer
  // ****************************************

  // One access at a time, each issued once and awaited
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    idx_d = idx_q;
    pend_d = pend_q;
    retry_d = retry_q;
    held_d = held_q;
    done_d = 1'b0;
    granted_d = granted_q;
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_wval = `DPS_FLAG_FREE;
    unique case (state_q)
      DPS_ST_INIT: begin
        // Free every flag from this port
        cyc_start = !pend_q;
        pend_d = 1'b1;
        if (cyc_done) begin
          pend_d = 1'b0;
          held_d[idx_q] = 1'b0;
          if (idx_q == `DPS_LAST_IDX) begin
            idx_d = '0;
            done_d = (op_q == DPS_OP_INIT);
            granted_d = 1'b0;
            state_d = DPS_ST_IDLE;
          end else begin
            idx_d = idx_q + 1'b1;
          end
        end
      end
      DPS_ST_IDLE: begin
        if (i_cmd_valid) begin
          op_d = i_cmd_op;
          idx_d = i_cmd_flag;
          retry_d = '0;
          unique case (i_cmd_op)
            DPS_OP_CLAIM_WAIT, DPS_OP_CLAIM_TRY: state_d = DPS_ST_REQ;
            DPS_OP_RELEASE: state_d = DPS_ST_FREE;
            DPS_OP_INIT: begin
              idx_d = '0;
              state_d = DPS_ST_INIT;
            end
          endcase
        end
      end
      DPS_ST_REQ: begin
        // Request by writing zero first
        cyc_start = !pend_q;
        cyc_wval = `DPS_FLAG_TAKEN;
        pend_d = 1'b1;
        if (cyc_done) begin
          pend_d = 1'b0;
          state_d = DPS_ST_TEST;
        end
      end
      DPS_ST_TEST: begin
        // Read back; zero means ours
        cyc_start = !pend_q;
        cyc_write = 1'b0;
        pend_d = 1'b1;
        if (cyc_done) begin
          pend_d = 1'b0;
          if (cyc_rval == `DPS_FLAG_TAKEN) begin
            held_d[idx_q] = 1'b1;
            granted_d = 1'b1;
            done_d = 1'b1;
            state_d = DPS_ST_DONE;
          end else if (op_q == DPS_OP_CLAIM_TRY ||
                       retry_q == `DPS_RETRY_MAX) begin
            granted_d = 1'b0;
            state_d = DPS_ST_FREE;
          end else begin
            retry_d = retry_q + 1'b1;
          end
        end
      end
      DPS_ST_FREE: begin
        // Release or withdraw a pending request
        cyc_start = !pend_q;
        pend_d = 1'b1;
        if (cyc_done) begin
          pend_d = 1'b0;
          held_d[idx_q] = 1'b0;
          if (op_q == DPS_OP_RELEASE) begin
            granted_d = 1'b0;
          end
          done_d = 1'b1;
          state_d = DPS_ST_DONE;
        end
      end
      DPS_ST_DONE: begin
        state_d = DPS_ST_IDLE;
      end
      default: begin
        state_d = DPS_ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************

  // Reset restarts the automatic flag init
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= DPS_ST_INIT;
      op_q <= DPS_OP_CLAIM_TRY;
      idx_q <= '0;
      pend_q <= 1'b0;
      retry_q <= '0;
      held_q <= '0;
      done_q <= 1'b0;
      granted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      idx_q <= idx_d;
      pend_q <= pend_d;
      retry_q <= retry_d;
      held_q <= held_d;
      done_q <= done_d;
      granted_q <= granted_d;
    end
  end

  // ****************************************
  // Result outputs
  // ****************************************

  // Ready only while waiting for a command
  assign o_cmd_ready = (state_q == DPS_ST_IDLE);
  assign o_done = done_q;
  assign o_granted = granted_q;
  assign o_held = held_q;

endmodule : dps_sem_host

// *** src/dps_sem_defs.svh ***
`ifndef DPS_SEM_DEFS_SVH
`define DPS_SEM_DEFS_SVH

// ****************************************
// Geometry of the token space
// ****************************************
`define DPS_FLAG_COUNT 8
`define DPS_IDX_W 3
`define DPS_DATA_W 16
`define DPS_LAST_IDX 3'h7

// ****************************************
// Flag values, active low
// ****************************************
`define DPS_FLAG_FREE 1'b1
`define DPS_FLAG_TAKEN 1'b0

// ****************************************
// Access timing
// ****************************************
`define DPS_CLK_NS 10
`define DPS_T_SETUP_NS 10
`define DPS_T_PULSE_NS 80
`define DPS_T_RECOV_NS 20
`define DPS_SETUP_CYC ((`DPS_T_SETUP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_PULSE_CYC ((`DPS_T_PULSE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_RECOV_CYC ((`DPS_T_RECOV_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_CNT_W 4

// ****************************************
// Claim retry limit
// ****************************************
`define DPS_RETRY_MAX 4'hF

`endif

// *** src/dps_sem_pkg.sv ***
package dps_sem_pkg;

  // Host commands
  typedef enum logic [1:0] {
    DPS_OP_CLAIM_WAIT = 2'h0,
    DPS_OP_CLAIM_TRY = 2'h1,
    DPS_OP_RELEASE = 2'h2,
    DPS_OP_INIT = 2'h3
  } dps_op_t;

  // Pin access sequencer states
  typedef enum logic [3:0] {
    DPS_CY_IDLE = 4'h1,
    DPS_CY_SETUP = 4'h2,
    DPS_CY_PULSE = 4'h4,
    DPS_CY_RECOV = 4'h8
  } dps_cyc_state_t;

  // Command sequencer states
  typedef enum logic [5:0] {
    DPS_ST_INIT = 6'h01,
    DPS_ST_IDLE = 6'h02,
    DPS_ST_REQ = 6'h04,
    DPS_ST_TEST = 6'h08,
    DPS_ST_FREE = 6'h10,
    DPS_ST_DONE = 6'h20
  } dps_state_t;

endpackage : dps_sem_pkg

// *** src/dps_sem_cycle.sv ***
`timescale 1ns/100ps
`include "dps_sem_defs.svh"

module dps_sem_cycle (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Access request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_wval,
  input wire logic [`DPS_IDX_W-1:0] i_flag,
  output logic o_done,
  output logic o_rval,
  // Device pins
  output logic o_token_space_select_n,
  output logic [`DPS_IDX_W-1:0] o_flag_index_lines,
  output logic o_rw_n,
  output logic o_oe_n,
  output logic [`DPS_DATA_W-1:0] o_port_data_lines,
  output logic o_port_data_lines_oe_n,
  input wire logic [`DPS_DATA_W-1:0] i_port_data_lines
);
  import dps_sem_pkg::*;

  dps_cyc_state_t state_q, state_d;
  logic [`DPS_CNT_W-1:0] cnt_q, cnt_d;
  logic write_q, write_d;
  logic sem_n_q, sem_n_d;
  logic [`DPS_IDX_W-1:0] idx_q, idx_d;
  logic rw_n_q, rw_n_d;
  logic oe_n_q, oe_n_d;
  logic [`DPS_DATA_W-1:0] dout_q, dout_d;
  logic doe_n_q, doe_n_d;
  logic done_q, done_d;
  logic rval_q, rval_d;
  logic [`DPS_DATA_W-1:0] sync1_q, sync2_q;

  // ****************************************
  // Read data synchroniser
  // ****************************************

  // Two stages before the data is looked at
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= i_port_data_lines;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************

  // Setup, strobe, recovery with select released
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    write_d = write_q;
    sem_n_d = sem_n_q;
    idx_d = idx_q;
    rw_n_d = rw_n_q;
    oe_n_d = oe_n_q;
    dout_d = dout_q;
    doe_n_d = doe_n_q;
    done_d = 1'b0;
    rval_d = rval_q;
    unique case (state_q)
      DPS_CY_IDLE: begin
        if (i_start) begin
          write_d = i_write;
          idx_d = i_flag;
          sem_n_d = 1'b0;
          if (i_write) begin
            dout_d = {`DPS_DATA_W{i_wval}};
            doe_n_d = 1'b0;
          end
          cnt_d = `DPS_CNT_W'(`DPS_SETUP_CYC - 1);
          state_d = DPS_CY_SETUP;
        end
      end
      DPS_CY_SETUP: begin
        if (cnt_q == '0) begin
          if (write_q) begin
            rw_n_d = 1'b0;
          end else begin
            oe_n_d = 1'b0;
          end
          cnt_d = `DPS_CNT_W'(`DPS_PULSE_CYC - 1);
          state_d = DPS_CY_PULSE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      DPS_CY_PULSE: begin
        if (cnt_q == '0) begin
          if (!write_q) begin
            rval_d = sync2_q[0];
          end
          rw_n_d = 1'b1;
          oe_n_d = 1'b1;
          sem_n_d = 1'b1;
          cnt_d = `DPS_CNT_W'(`DPS_RECOV_CYC - 1);
          state_d = DPS_CY_RECOV;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      DPS_CY_RECOV: begin
        if (cnt_q == '0) begin
          doe_n_d = 1'b1; // Data held past strobe end
          done_d = 1'b1;
          state_d = DPS_CY_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = DPS_CY_IDLE;
      end
    endcase
  end

  // Register next values, pins idle in reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= DPS_CY_IDLE;
      cnt_q <= '0;
      write_q <= 1'b0;
      sem_n_q <= 1'b1;
      idx_q <= '0;
      rw_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dout_q <= '0;
      doe_n_q <= 1'b1;
      done_q <= 1'b0;
      rval_q <= `DPS_FLAG_FREE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      write_q <= write_d;
      sem_n_q <= sem_n_d;
      idx_q <= idx_d;
      rw_n_q <= rw_n_d;
      oe_n_q <= oe_n_d;
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
      done_q <= done_d;
      rval_q <= rval_d;
    end
  end

  // Pins straight from flops
  assign o_done = done_q;
  assign o_rval = rval_q;
  assign o_token_space_select_n = sem_n_q;
  assign o_flag_index_lines = idx_q;
  assign o_rw_n = rw_n_q;
  assign o_oe_n = oe_n_q;
  assign o_port_data_lines = dout_q;
  assign o_port_data_lines_oe_n = doe_n_q;

endmodule : dps_sem_cycle

// *** bench/dps_sem_monitor.sv ***
`timescale 1ns/100ps
`include "dps_sem_defs.svh"

module dps_sem_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Host outputs
  input wire logic o_cmd_ready,
  input wire logic o_done,
  input wire logic o_token_space_select_n,
  input wire logic [`DPS_IDX_W-1:0] o_flag_index_lines,
  input wire logic o_rw_n,
  input wire logic o_oe_n,
  input wire logic [`DPS_DATA_W-1:0] o_port_data_lines,
  input wire logic o_port_data_lines_oe_n
);
  // ****
  // Pin access and handshake checks
  // ****
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // Strobe low eight cycles, then high
  sequence s_pulse(x);
    !x [*7] ##1 x;
  endsequence

  a_write_width: assert property (
    $fell(o_rw_n) |=> s_pulse(o_rw_n)) else $error("write width");
  a_read_width: assert property (
    $fell(o_oe_n) |=> s_pulse(o_oe_n)) else $error("read width");
  a_select_setup: assert property (
    $fell(o_token_space_select_n) |=> $fell(o_rw_n) || $fell(o_oe_n))
    else $error("no strobe after select");
  a_strobe_select: assert property (
    (!o_rw_n || !o_oe_n) |-> !o_token_space_select_n)
    else $error("strobe outside select");
  a_write_data: assert property (
    !o_rw_n |-> !o_port_data_lines_oe_n &&
    o_port_data_lines == {16{o_port_data_lines[0]}})
    else $error("write data");
  a_poll_gap: assert property (
    $rose(o_token_space_select_n) |=> o_token_space_select_n)
    else $error("select gap short");
  a_index_hold: assert property (
    !o_token_space_select_n && !$past(o_token_space_select_n)
    |-> $stable(o_flag_index_lines)) else $error("index moved");
  a_done_ready: assert property (
    o_done |=> o_cmd_ready && !o_done) else $error("done or ready");
endmodule : dps_sem_monitor

bind dps_sem_host dps_sem_monitor u_mon (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_cmd_ready(o_cmd_ready),
  .o_done(o_done), .o_token_space_select_n(o_token_space_select_n),
  .o_flag_index_lines(o_flag_index_lines), .o_rw_n(o_rw_n),
  .o_oe_n(o_oe_n), .o_port_data_lines(o_port_data_lines),
  .o_port_data_lines_oe_n(o_port_data_lines_oe_n));

// *** bench/dps_sem_device.sv ***
`timescale 1ns/100ps

module dps_sem_device (
  // Clock
  input wire logic i_mclk,
  // Host side pins
  input wire logic i_sel_n,
  input wire logic [2:0] i_idx,
  input wire logic i_rw_n,
  input wire logic i_oe_n,
  input wire logic [15:0] i_wdata,
  input wire logic i_wdata_oe_n,
  output logic [15:0] o_rdata,
  // Far side writes and flag views
  input wire logic i_b_we,
  input wire logic [2:0] i_b_idx,
  input wire logic i_b_wd,
  output logic [7:0] o_a_view,
  output logic [7:0] o_b_view
);
  // Eight flags, request latches power up requested
  logic [7:0] req_a_q = 8'h00;
  logic [7:0] req_b_q = 8'h00;
  logic [7:0] own_a_q = 8'h00;
  logic [7:0] own_b_q = 8'h00;
  logic [7:0] req_a_d, req_b_d, own_a_d, own_b_d;
  logic rd_q = 1'b1;
  logic rd_on_q = 1'b0;
  logic [15:0] bus_q = 16'h0000;
  logic rd_now;

  // Latch writes, arbitrate, ties to host side
  always_comb begin
    req_a_d = req_a_q;
    req_b_d = req_b_q;
    if (!i_sel_n && !i_rw_n) req_a_d[i_idx] = i_wdata[0];
    if (i_b_we) req_b_d[i_b_idx] = i_b_wd;
    own_a_d = own_a_q & ~req_a_d;
    own_b_d = own_b_q & ~req_b_d;
    own_a_d = own_a_d | (~own_b_d & ~req_a_d);
    own_b_d = own_b_d | (~own_a_d & ~req_b_d);
    rd_now = rd_on_q ? rd_q : !own_a_q[i_idx];
  end

  // Data wire: host drive, spread flag, else drifting
  assign o_rdata = !i_wdata_oe_n ? i_wdata :
    (!i_sel_n && !i_oe_n) ? {16{rd_now}} : ~bus_q;
  assign o_a_view = ~own_a_q;
  assign o_b_view = ~own_b_q;

  // Register latches and read hold
  always_ff @(posedge i_mclk) begin
    req_a_q <= req_a_d;
    req_b_q <= req_b_d;
    own_a_q <= own_a_d;
    own_b_q <= own_b_d;
    rd_on_q <= !i_sel_n && !i_oe_n;
    rd_q <= rd_now;
    bus_q <= o_rdata;
  end
endmodule : dps_sem_device

// *** bench/test_dps_sem_host.sv ***
`timescale 1ns/100ps

module test_dps_sem_host;
  import dps_sem_pkg::*;
  // Driven inputs
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cmd_valid = 1'b0;
  dps_op_t i_cmd_op = DPS_OP_INIT;
  logic [2:0] i_cmd_flag = 3'h0;
  logic b_we = 1'b0;
  logic b_wd = 1'b1;
  logic [2:0] b_idx = 3'h0;
  // Observed outputs
  logic ready, done, granted, sel_n, rw_n, oe_n, dq_oe_n;
  logic [7:0] held, a_view, b_view;
  logic [2:0] idx;
  logic [15:0] dq_o, dq_i;
  // Reference ownership
  int own_h[8], own_b[8], pend[8];
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h3;

  `define DPS_CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end

  always #5 i_mclk = ~i_mclk;

  dps_sem_host u_dps_sem_host (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_flag(i_cmd_flag), .o_cmd_ready(ready),
    .o_done(done), .o_granted(granted), .o_held(held),
    .o_token_space_select_n(sel_n), .o_flag_index_lines(idx),
    .o_rw_n(rw_n), .o_oe_n(oe_n), .o_port_data_lines(dq_o),
    .o_port_data_lines_oe_n(dq_oe_n), .i_port_data_lines(dq_i));
  dps_sem_device u_dps_sem_device (
    .i_mclk(i_mclk), .i_sel_n(sel_n), .i_idx(idx), .i_rw_n(rw_n),
    .i_oe_n(oe_n), .i_wdata(dq_o), .i_wdata_oe_n(dq_oe_n),
    .o_rdata(dq_i), .i_b_we(b_we), .i_b_idx(b_idx), .i_b_wd(b_wd),
    .o_a_view(a_view), .o_b_view(b_view));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Bounded wait at falling edges for ready or done
  task automatic wait_flag(input int which);
    for (int k = 0; k < 400; k++) begin
      @(negedge i_mclk);
      if ((which ? done : ready) === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    print_verdict();
  endtask : wait_flag

  // Host release in the reference, pending side takes over
  function automatic void h_free(input int f);
    if (own_h[f] != 0 && pend[f] != 0) own_b[f] = 1;
    own_h[f] = 0;
    pend[f] = 0;
  endfunction : h_free

  // Far side writes one flag
  task automatic b_write(input int f, input logic v);
    @(posedge i_mclk);
    b_idx <= f[2:0];
    b_wd <= v;
    b_we <= 1'b1;
    @(posedge i_mclk);
    b_we <= 1'b0;
    if (v) own_b[f] = 0;
    else if (own_h[f] != 0) pend[f] = 1;
    else own_b[f] = 1;
    if (v) pend[f] = 0;
  endtask : b_write

  // Issue one command and compare the outcome
  task automatic do_cmd(input dps_op_t op, input int f);
    logic [7:0] eh, eb;
    @(posedge i_mclk);
    i_cmd_op <= op;
    i_cmd_flag <= f[2:0];
    i_cmd_valid <= 1'b1;
    wait_flag(0);
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    wait_flag(1);
    if (op == DPS_OP_INIT) for (int i = 0; i < 8; i++) h_free(i);
    else if (op == DPS_OP_RELEASE) h_free(f);
    else if (own_b[f] == 0) own_h[f] = 1;
    for (int i = 0; i < 8; i++) begin
      eh[i] = own_h[i] != 0;
      eb[i] = own_b[i] != 0;
    end
    `DPS_CHK(granted, op <= DPS_OP_CLAIM_TRY && own_h[f] != 0)
    `DPS_CHK(held, eh)
    `DPS_CHK(a_view, ~eh)
    `DPS_CHK(b_view, ~eb)
  endtask : do_cmd

  // Main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) b_write(i, 1'b1);
    do_cmd(DPS_OP_CLAIM_TRY, 7);
    b_write(7, 1'b0);
    do_cmd(DPS_OP_RELEASE, 7);
    do_cmd(DPS_OP_CLAIM_TRY, 7);
    fork
      do_cmd(DPS_OP_CLAIM_WAIT, 7);
      begin
        repeat (100) @(posedge i_mclk);
        b_write(7, 1'b1);
      end
    join
    for (int n = 0; n < 40; n++) begin
      rng = xs(rng);
      if (rng[8]) b_write(rng[2:0], rng[9]);
      do_cmd(dps_op_t'(rng[5:4]), rng[2:0]);
    end
    print_verdict();
  end
endmodule : test_dps_sem_host
